// file: rtl/atdc_params.svh
// Constants of the threshold / DC-removal / channel 0 register slice.
// Assumes an APB master with 32-bit data; registers sit at word index times four.
// How it works
// (R1) The low eight threshold bits are kept in bits 15:8 of the threshold-low register.
// (R2) The upper sixteen threshold bits are kept in their own register one index below.
// (R3) A four-bit DC-removal select sits in bits 3:0, and code zero switches the filter off.
// (R4) Codes one to fifteen give a coefficient of 1/4 down to 1/65536, halving per step.
// (R5) The threshold-low register is at index 8h and resets to all zeros.
// (R6) The channel 0 configuration register is at index 9h and resets to all zeros.
// (R7) Channel 0 phase delay is a ten-bit two's-complement count in bits 15:6.
// (R8) Bit 2 of channel 0 configuration set bypasses DC removal for channel 0 only.
// (R9) The two-bit input select picks normal pair, shorted, positive or negative test signal.
// (R10) Reserved bits read as zero and ignore writes; software writes them as zero.
`ifndef ATDC_PARAMS_SVH
`define ATDC_PARAMS_SVH

// Register indices and byte addresses
`define ATDC_IDX_THR_HIGH 4'h7
`define ATDC_IDX_THR_LOW 4'h8
`define ATDC_IDX_CHANNEL0_CONFIG 4'h9
`define ATDC_ADDR_W 12
`define ATDC_ADDR_THR_HIGH 12'h01C
`define ATDC_ADDR_THR_LOW 12'h020
`define ATDC_ADDR_CHANNEL0_CONFIG 12'h024

// Field positions
`define ATDC_THR_LOW_MSB 15
`define ATDC_THR_LOW_LSB 8
`define ATDC_DC_SEL_MSB 3
`define ATDC_DC_SEL_LSB 0
`define ATDC_PHASE_MSB 15
`define ATDC_PHASE_LSB 6
`define ATDC_DC_OFF_BIT 2
`define ATDC_IN_SEL_MSB 1
`define ATDC_IN_SEL_LSB 0

// Reset values
`define ATDC_RST_THR_HIGH 16'h0000
`define ATDC_RST_THR_LOW 16'h0000
`define ATDC_RST_CHANNEL0_CONFIG 16'h0000

// Coefficient shift offset: code one means a shift of two
`define ATDC_SHIFT_OFS 5'h01

`endif

// file: rtl/atdc_pkg.sv
// Types shared by the register slice and its decoders.
// Assumes atdc_params.svh provides all numeric constants.
package atdc_pkg;

  typedef enum logic [0:0] {
    ATDC_IDLE = 1'b0,
    ATDC_ACCESS = 1'b1
  } atdc_apb_st_type;

  typedef enum logic [1:0] {
    ATDC_IN_NORMAL = 2'b00,
    ATDC_IN_SHORT = 2'b01,
    ATDC_IN_POS_TEST = 2'b10,
    ATDC_IN_NEG_TEST = 2'b11
  } atdc_in_sel_type;

  typedef struct packed {
    logic [15:0] thr_high;
    logic [7:0] thr_low;
    logic [3:0] dc_sel;
    logic signed [9:0] phase;
    logic dc_off;
    atdc_in_sel_type in_sel;
    atdc_apb_st_type apb_st;
    logic [31:0] prdata;
    logic pslverr;
    logic dc_on;
    logic ch0_dc_on;
    logic [4:0] coeff_shift;
    logic [3:0] route;
  } atdc_state_type;

endpackage

// file: rtl/atdc_cfg_if.sv
// Carrier between the register slice and its two field decoders.
// Assumes all members are combinational within one clock domain.
`timescale 1ns/100ps
interface atdc_cfg_if;
  import atdc_pkg::*;

  logic [3:0] dc_sel;
  logic dc_off;
  atdc_in_sel_type in_sel;
  logic dc_on;
  logic ch0_dc_on;
  logic [4:0] coeff_shift;
  logic [3:0] route;

  modport regs (
    output dc_sel,
    output dc_off,
    output in_sel,
    input dc_on,
    input ch0_dc_on,
    input coeff_shift,
    input route
  );

  modport dcdec (
    input dc_sel,
    input dc_off,
    output dc_on,
    output ch0_dc_on,
    output coeff_shift
  );

  modport muxdec (
    input in_sel,
    output route
  );
endinterface

// file: rtl/atdc_dc_decode.sv
// Decodes the DC-removal select into an enable and a coefficient shift.
// Assumes the select and override come from registers on the same clock.
`timescale 1ns/100ps
`include "atdc_params.svh"
module atdc_dc_decode (
  atdc_cfg_if.dcdec cfg // Field carrier
);
  import atdc_pkg::*;

  always_comb begin
    // (R3) Code zero disables
    cfg.dc_on = (cfg.dc_sel != 4'h0);
    // (R4) Shift of code plus one
    if (cfg.dc_sel != 4'h0) begin
      cfg.coeff_shift = {1'b0, cfg.dc_sel} + `ATDC_SHIFT_OFS;
    end else begin
      cfg.coeff_shift = 5'h00;
    end
    // (R8) Per-channel bypass
    cfg.ch0_dc_on = cfg.dc_on & ~cfg.dc_off;
  end

endmodule // atdc_dc_decode

// file: rtl/atdc_mux_decode.sv
// Turns the channel 0 input select into a one-hot switch control.
// Assumes the select comes from a register on the same clock.
`timescale 1ns/100ps
`include "atdc_params.svh"
module atdc_mux_decode (
  atdc_cfg_if.muxdec cfg // Field carrier
);
  import atdc_pkg::*;

  // (R9) One-hot input route
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_route
      assign cfg.route[gi] = (cfg.in_sel == atdc_in_sel_type'(2'(gi)));
    end
  endgenerate

endmodule // atdc_mux_decode

// file: rtl/atdc_top.sv
// APB register slice: current-detect threshold, DC-removal select and
// channel 0 configuration, with decoded controls for the datapath.
// Assumes an APB master on clk_i; the datapath samples the outputs on clk_i.
`timescale 1ns/100ps
`include "atdc_params.svh"
module atdc_top (
  input wire logic clk_i, // 20 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction, high write
  input wire logic [`ATDC_ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [3:0] pstrb_i, // APB write byte strobes
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error for unmapped access
  output logic [23:0] cur_detect_threshold_o, // Full threshold
  output logic [3:0] dc_removal_coeff_sel_o, // Global DC-removal select
  output logic dc_removal_on_o, // Global filter enabled
  output logic [4:0] dc_coeff_shift_o, // Coefficient is 2^-shift
  output logic signed [9:0] ch0_phase_delay_o, // Phase delay, modulator cycles
  output logic ch0_dc_removal_off_o, // Channel 0 bypass bit
  output logic ch0_dc_removal_on_o, // Filter active on channel 0
  output atdc_pkg::atdc_in_sel_type ch0_input_select_o, // Input select code
  output logic [3:0] ch0_route_o // One-hot: normal, short, pos, neg
);
  import atdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and decoders
  ////////////////////////////////////////////////////////////////////////////

  atdc_state_type st_ff;
  atdc_state_type nxt_st;
  atdc_cfg_if cfg ();

  logic setup;
  logic access;
  logic hit_high;
  logic hit_low;
  logic hit_cfg;
  logic addr_ok;
  logic [15:0] wmask;
  logic [15:0] thr_high_rd;
  logic [15:0] thr_low_rd;
  logic [15:0] cfg_rd;
  logic [15:0] rd_word;

  assign cfg.dc_sel = st_ff.dc_sel;
  assign cfg.dc_off = st_ff.dc_off;
  assign cfg.in_sel = st_ff.in_sel;

  atdc_dc_decode u_dc_decode (
    .cfg(cfg.dcdec)
  );

  atdc_mux_decode u_mux_decode (
    .cfg(cfg.muxdec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read view
  ////////////////////////////////////////////////////////////////////////////

  // (R2) Threshold high one index below
  assign hit_high = (paddr_i == `ATDC_ADDR_THR_HIGH);
  // (R5) Threshold-low placement
  assign hit_low = (paddr_i == `ATDC_ADDR_THR_LOW);
  // (R6) Channel 0 config placement
  assign hit_cfg = (paddr_i == `ATDC_ADDR_CHANNEL0_CONFIG);
  assign addr_ok = hit_high | hit_low | hit_cfg;

  assign setup = ce_i & psel_i & ~penable_i;
  assign access = psel_i & penable_i & (st_ff.apb_st == ATDC_ACCESS);

  // Byte strobes gate the two low lanes; upper lanes hold nothing
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  // (R10) Reserved bits read zero
  always_comb begin
    thr_high_rd = st_ff.thr_high;
    thr_low_rd = 16'h0000;
    thr_low_rd[`ATDC_THR_LOW_MSB:`ATDC_THR_LOW_LSB] = st_ff.thr_low;
    thr_low_rd[`ATDC_DC_SEL_MSB:`ATDC_DC_SEL_LSB] = st_ff.dc_sel;
    cfg_rd = 16'h0000;
    cfg_rd[`ATDC_PHASE_MSB:`ATDC_PHASE_LSB] = st_ff.phase;
    cfg_rd[`ATDC_DC_OFF_BIT] = st_ff.dc_off;
    cfg_rd[`ATDC_IN_SEL_MSB:`ATDC_IN_SEL_LSB] = st_ff.in_sel;
  end

  always_comb begin
    if (hit_high) begin
      rd_word = thr_high_rd;
    end else if (hit_low) begin
      rd_word = thr_low_rd;
    end else if (hit_cfg) begin
      rd_word = cfg_rd;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // Merges strobed write data into a 16-bit register image
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [15:0] img;
    img = 16'h0000;
    nxt_st = st_ff;

    unique case (st_ff.apb_st)
      ATDC_IDLE: begin
        if (setup) begin
          nxt_st.apb_st = ATDC_ACCESS;
        end
      end
      ATDC_ACCESS: begin
        if (access) begin
          nxt_st.apb_st = ATDC_IDLE;
        end else if (!psel_i) begin
          nxt_st.apb_st = ATDC_IDLE;
        end
      end
    endcase

    // Read data and error are captured in the setup cycle so that they
    // come from flip-flops while the access phase stands
    if (setup) begin
      nxt_st.pslverr = ~addr_ok | (paddr_i[1:0] != 2'b00);
      nxt_st.prdata = (!pwrite_i) ? {16'h0000, rd_word} : 32'h0000_0000;
    end

    // Writes land only at the access edge, mapped address only
    if (access && pwrite_i && !st_ff.pslverr) begin
      if (hit_high) begin
        // (R2) Upper threshold write
        nxt_st.thr_high = merge(st_ff.thr_high, pwdata_i[15:0], wmask);
      end
      if (hit_low) begin
        img = merge(thr_low_rd, pwdata_i[15:0], wmask);
        // (R1) Threshold low byte
        nxt_st.thr_low = img[`ATDC_THR_LOW_MSB:`ATDC_THR_LOW_LSB];
        // (R3) DC-removal select store
        nxt_st.dc_sel = img[`ATDC_DC_SEL_MSB:`ATDC_DC_SEL_LSB];
      end
      if (hit_cfg) begin
        img = merge(cfg_rd, pwdata_i[15:0], wmask);
        // (R7) Signed phase delay
        nxt_st.phase = img[`ATDC_PHASE_MSB:`ATDC_PHASE_LSB];
        // (R8) Channel bypass bit
        nxt_st.dc_off = img[`ATDC_DC_OFF_BIT];
        // (R9) Input select store
        nxt_st.in_sel = atdc_in_sel_type'(img[`ATDC_IN_SEL_MSB:`ATDC_IN_SEL_LSB]);
      end
    end

    // Decoded controls are registered one cycle after the fields
    nxt_st.dc_on = cfg.dc_on;
    nxt_st.ch0_dc_on = cfg.ch0_dc_on;
    nxt_st.coeff_shift = cfg.coeff_shift;
    nxt_st.route = cfg.route;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff.thr_high <= `ATDC_RST_THR_HIGH;
      // (R5) Threshold-low clears
      st_ff.thr_low <= 8'(`ATDC_RST_THR_LOW >> `ATDC_THR_LOW_LSB);
      st_ff.dc_sel <= 4'h0;
      // (R6) Channel 0 config clears
      st_ff.phase <= 10'(`ATDC_RST_CHANNEL0_CONFIG >> `ATDC_PHASE_LSB);
      st_ff.dc_off <= 1'b0;
      st_ff.in_sel <= ATDC_IN_NORMAL;
      st_ff.apb_st <= ATDC_IDLE;
      st_ff.prdata <= 32'h0000_0000;
      st_ff.pslverr <= 1'b0;
      st_ff.dc_on <= 1'b0;
      st_ff.ch0_dc_on <= 1'b0;
      st_ff.coeff_shift <= 5'h00;
      st_ff.route <= 4'h1;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  // Zero-wait answer; a low clock enable stalls the transfer
  assign pready_o = ce_i & access;
  assign pslverr_o = ce_i & access & st_ff.pslverr;
  assign prdata_o = st_ff.prdata;

  // (R1) Threshold assembled for the detector
  assign cur_detect_threshold_o = {st_ff.thr_high, st_ff.thr_low};
  assign dc_removal_coeff_sel_o = st_ff.dc_sel;
  assign dc_removal_on_o = st_ff.dc_on;
  assign dc_coeff_shift_o = st_ff.coeff_shift;
  assign ch0_phase_delay_o = st_ff.phase;
  assign ch0_dc_removal_off_o = st_ff.dc_off;
  assign ch0_dc_removal_on_o = st_ff.ch0_dc_on;
  assign ch0_input_select_o = st_ff.in_sel;
  assign ch0_route_o = st_ff.route;

endmodule // atdc_top

// file: dv/atdc_top_assertions.sv
// Concurrent checks for the threshold and channel 0 register slice.
// Assumes a bind onto atdc_top; one clock, synchronous reset.
`timescale 1ns/100ps
`include "atdc_params.svh"
module atdc_top_assertions (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic ce_i, // Enable
  input wire logic psel_i, // Select
  input wire logic penable_i, // Access
  input wire logic pwrite_i, // Write
  input wire logic [`ATDC_ADDR_W-1:0] paddr_i, // Address
  input wire logic [31:0] pwdata_i, // Wdata
  input wire logic [3:0] pstrb_i, // Strobes
  input wire logic [31:0] prdata_o, // Rdata
  input wire logic pready_o, // Ready
  input wire logic pslverr_o, // Error
  input wire logic [23:0] cur_detect_threshold_o, // Threshold
  input wire logic [3:0] dc_removal_coeff_sel_o, // Select
  input wire logic dc_removal_on_o, // Filter on
  input wire logic [4:0] dc_coeff_shift_o, // Shift
  input wire logic signed [9:0] ch0_phase_delay_o, // Phase
  input wire logic ch0_dc_removal_off_o, // Bypass
  input wire logic ch0_dc_removal_on_o, // Ch0 on
  input wire atdc_pkg::atdc_in_sel_type ch0_input_select_o, // Input
  input wire logic [3:0] ch0_route_o // Route
);
  import atdc_pkg::*;
  logic acc;
  logic wr3;
  logic [31:0] wd_ff;
  assign acc = psel_i && penable_i && pready_o;
  assign wr3 = acc && pwrite_i && pstrb_i[1:0] == 2'h3;
  always_ff @(posedge clk_i) begin
    wd_ff <= pwdata_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_upd;
    !$past(rst_i) && $past(ce_i);
  endsequence
  //////////////////////////////////////////////////
  property p_rst_clr;
    disable iff (1'b0) rst_i |=> cur_detect_threshold_o == 24'h0 && ch0_phase_delay_o == 10'h0
      && dc_removal_coeff_sel_o == 4'h0 && !ch0_dc_removal_off_o && ch0_route_o == 4'h1;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("reset values wrong");
  property p_dc_on;
    s_upd |-> dc_removal_on_o == ($past(dc_removal_coeff_sel_o) != 4'h0);
  endproperty
  a_dc_on: assert property (p_dc_on) else $error("filter enable wrong");
  property p_shift;
    s_upd |-> dc_coeff_shift_o == ($past(dc_removal_coeff_sel_o) == 4'h0 ? 5'h00 :
      {1'b0, $past(dc_removal_coeff_sel_o)} + 5'h01);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_ch0_on;
    s_upd |-> ch0_dc_removal_on_o ==
      ($past(dc_removal_coeff_sel_o) != 4'h0 && !$past(ch0_dc_removal_off_o));
  endproperty
  a_ch0_on: assert property (p_ch0_on) else $error("ch0 filter wrong");
  property p_route;
    s_upd |-> ch0_route_o == 4'h1 << $past(ch0_input_select_o);
  endproperty
  a_route: assert property (p_route) else $error("route wrong");
  property p_wr_low;
    wr3 && paddr_i == `ATDC_ADDR_THR_LOW |=> cur_detect_threshold_o[7:0] == wd_ff[15:8]
      && dc_removal_coeff_sel_o == wd_ff[3:0];
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low write lost");
  property p_wr_high;
    wr3 && paddr_i == `ATDC_ADDR_THR_HIGH |=> cur_detect_threshold_o[23:8] == wd_ff[15:0];
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high write lost");
  property p_wr_cfg;
    wr3 && paddr_i == `ATDC_ADDR_CHANNEL0_CONFIG |=> ch0_phase_delay_o == wd_ff[15:6]
      && ch0_dc_removal_off_o == wd_ff[2] && ch0_input_select_o == wd_ff[1:0];
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("cfg write lost");
  property p_rd_resv;
    acc && !pwrite_i |-> prdata_o[31:16] == 16'h0 && (paddr_i != `ATDC_ADDR_THR_LOW ||
      prdata_o[7:4] == 4'h0) && (paddr_i != `ATDC_ADDR_CHANNEL0_CONFIG || prdata_o[5:3] == 3'h0);
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bits set");
  c_wr_low: cover property (wr3 && paddr_i == `ATDC_ADDR_THR_LOW);
  c_err: cover property (acc && pslverr_o);
  c_neg: cover property (ch0_route_o == 4'h8);
  c_stall: cover property (psel_i && penable_i && !ce_i);
endmodule // atdc_top_assertions
bind atdc_top atdc_top_assertions u_chk (.*);

// file: dv/adc_threshold_dc_removal_coeff_sel_ch0_config_tb.sv
// Bench for the threshold, DC-removal and channel 0 register slice.
// Assumes atdc_top with its bound checker; APB master at 20 MHz.
`timescale 1ns/100ps
`include "atdc_params.svh"
module adc_threshold_dc_removal_coeff_sel_ch0_config_tb;
  import atdc_pkg::*;
  localparam logic [11:0] HI = `ATDC_ADDR_THR_HIGH;
  localparam logic [11:0] LO = `ATDC_ADDR_THR_LOW;
  localparam logic [11:0] CF = `ATDC_ADDR_CHANNEL0_CONFIG;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [23:0] thr;
  logic dc_on;
  logic [4:0] shift;
  logic signed [9:0] phase;
  logic ch0_on;
  logic [3:0] route;
  int bad_count = 0;
  int tests_run = 0;
  int waits;
  int stall = 0;
  atdc_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cur_detect_threshold_o(thr), .dc_removal_coeff_sel_o(), .dc_removal_on_o(dc_on),
    .dc_coeff_shift_o(shift), .ch0_phase_delay_o(phase), .ch0_dc_removal_off_o(),
    .ch0_dc_removal_on_o(ch0_on), .ch0_input_select_o(), .ch0_route_o(route)
  );
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic x);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    ce_i <= (stall == 0);
    for (waits = 0; waits < 20; waits++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
      ce_i <= (waits + 1 >= stall);
    end
    if (waits == 20) begin
      bad_count++;
      print_verdict();
    end
    if (!w) chk(prdata_o, e);
    chk({31'h0, pslverr_o}, {31'h0, x});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  //////////////////////////////////////////////////
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, LO, 32'h0, 32'h0, 1'b0); // cleared
    apb(1'b0, CF, 32'h0, 32'h0, 1'b0); // cleared
    apb(1'b0, HI, 32'h0, 32'h0, 1'b0); // cleared
    @(negedge clk_i);
    chk({8'h0, thr}, 32'h0); // threshold zero
    chk({28'h0, route}, 32'h1); // normal pair
  endtask
  task automatic t_thr;
    apb(1'b1, LO, 32'hFFFFFFFF, 32'h0, 1'b0); // reserved dropped
    apb(1'b0, LO, 32'h0, 32'hFF0F, 1'b0); // low byte kept
    pstrb_i <= 4'h1;
    apb(1'b1, LO, 32'h0, 32'h0, 1'b0); // lane zero only
    pstrb_i <= 4'hF;
    apb(1'b0, LO, 32'h0, 32'hFF00, 1'b0); // upper lane kept
    apb(1'b1, HI, 32'h0000A5C3, 32'h0, 1'b0); // high part
    apb(1'b0, HI, 32'h0, 32'hA5C3, 1'b0); // readback
    @(negedge clk_i);
    chk({8'h0, thr}, 32'hA5C3FF); // joined value
  endtask
  task automatic t_dc;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, LO, {16'h0, 8'h3C, 4'h0, c[3:0]}, 32'h0, 1'b0); // select
      repeat (2) @(negedge clk_i);
      chk({31'h0, dc_on}, {31'h0, c != 0}); // zero turns off
      chk({27'h0, shift}, c == 0 ? 32'h0 : c + 1); // halving steps
      chk({31'h0, ch0_on}, {31'h0, c != 0}); // follows global
    end
  endtask
  task automatic t_ch0;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CF, {16'hFFFF, 10'h200, 3'h7, m[0], m[1:0]}, 32'h0, 1'b0);
      apb(1'b0, CF, 32'h0, {16'h0, 10'h200, 3'h0, m[0], m[1:0]}, 1'b0);
      @(negedge clk_i);
      chk({22'h0, phase}, 32'h200); // most negative
      chk({28'h0, route}, 32'h1 << m); // every select
      chk({31'h0, ch0_on}, {31'h0, !m[0]}); // bypass
      chk({31'h0, dc_on}, 32'h1); // global untouched
    end
  endtask
  task automatic t_bad;
    apb(1'b1, 12'h028, 32'hFFFF, 32'h0, 1'b1); // unmapped
    apb(1'b0, 12'h022, 32'h0, 32'h0, 1'b1); // unaligned
    apb(1'b0, LO, 32'h0, 32'h3C0F, 1'b0); // unchanged
  endtask
  task automatic t_stall;
    stall = 3;
    apb(1'b0, CF, 32'h0, 32'h8007, 1'b0); // held through stall
    stall = 0;
    chk(waits, 32'h3);
  endtask
  initial begin
    t_reset();
    t_thr();
    t_dc();
    t_ch0();
    t_bad();
    t_stall();
    t_reset();
    print_verdict();
  end
endmodule // adc_threshold_dc_removal_coeff_sel_ch0_config_tb
